// File: core/nfc_pkg.sv
`default_nettype none
// Shared constants for the parallel NOR flash host controller
package nfc_pkg;
   // System clock period and bus timing
   localparam int CLK_NS = 10;
   localparam int T_WE_LOW_NS = 70;
   localparam int T_READ_ACC_NS = 110;
   localparam int T_RESET_LOW_NS = 25000;
   localparam int SYNC_CYC = 3;
   localparam int WE_CYC = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACC_CYC = (T_READ_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int RST_CYC = (T_RESET_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 12;

   // Software register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_COUNT = 8'h0c;
   localparam logic [7:0] REG_BUFDATA = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;

   // Operation codes written to the control register
   localparam logic [3:0] OP_RD_ARRAY = 4'h1;
   localparam logic [3:0] OP_RD_STATUS = 4'h2;
   localparam logic [3:0] OP_RD_ID = 4'h3;
   localparam logic [3:0] OP_RD_QUERY = 4'h4;
   localparam logic [3:0] OP_CLR_STATUS = 4'h5;
   localparam logic [3:0] OP_WORD_PROG = 4'h6;
   localparam logic [3:0] OP_BUF_PROG = 4'h7;
   localparam logic [3:0] OP_RESET = 4'h8;

   // Flash command codes
   localparam logic [15:0] CMD_READ_ARRAY = 16'h00ff;
   localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
   localparam logic [15:0] CMD_READ_ID = 16'h0090;
   localparam logic [15:0] CMD_QUERY = 16'h0098;
   localparam logic [15:0] CMD_CLR_STATUS = 16'h0050;
   localparam logic [15:0] CMD_WORD_PROG = 16'h0040;
   localparam logic [15:0] CMD_BUF_PROG = 16'h00e8;
   localparam logic [15:0] CMD_CONFIRM = 16'h00d0;

   // Status byte bit positions and identifier offsets
   localparam int SB_READY = 7;
   localparam int SB_SEQ_ERR = 5;
   localparam int SB_PROG_ERR = 4;
   localparam int SB_PROGRAM_ENABLE_VOLTAGE_ERR = 3;
   localparam int SB_LOCK_ERR = 1;
   localparam logic [7:0] ID_BLOCK_LOCK = 8'h02;
   localparam logic [7:0] ID_COMPAT = 8'h03;
   localparam logic [7:0] ID_GENERAL_READOUT = 8'h07;
   localparam logic [7:0] ID_OTP_LOCK = 8'h80;

   // Buffered programming limits, in words
   localparam int BUF_WORDS = 512;
   localparam int BUF_SPLIT_WORDS = 256;
   localparam int BLOCK_WORDS = 65536;

   // Software status register field positions
   localparam int ST_BUSY = 0;
   localparam int ST_NEED_DATA = 1;
   localparam int ST_ARG_ERR = 2;
   localparam int ST_READY_PIN = 3;
   localparam int ST_MODE = 4;
   localparam int ST_STATUS_BYTE = 8;

   // Read mode the flash is believed to be in
   typedef enum logic [1:0] {RM_ARRAY, RM_STATUS, RM_ID, RM_QUERY} nfc_rmode_t;
endpackage
`default_nettype wire

// File: core/nfc_cyc_if.sv
`default_nettype none
// One flash bus cycle: request from the sequencer, answer from the engine
interface nfc_cyc_if;
   logic req;
   logic wr;
   logic [23:0] addr;
   logic [15:0] wdata;
   logic ack;
   logic [15:0] rdata;
   modport ctl (output req, output wr, output addr, output wdata, input ack, input rdata);
   modport eng (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface
`default_nettype wire

// File: core/nfc_bus_eng.sv
`default_nettype none
// Drives one asynchronous write or read cycle on the flash pins
module nfc_bus_eng (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Cycle request
   nfc_cyc_if.eng cyc,
   // Flash pins
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic [23:0] o_addr,
   output logic [15:0] o_dq,
   output logic o_dq_oe,
   input wire logic [15:0] i_dq
);
   import nfc_pkg::*;

   typedef enum {E_IDLE, E_SETUP, E_STROBE, E_HOLD} nfc_eng_state_t;

   nfc_eng_state_t st_q, st_d;
   logic wr_q, wr_d, ack_q, ack_d;
   logic ce_n_d, oe_n_d, we_n_d, dq_oe_d;
   logic [23:0] addr_d;
   logic [15:0] dq_d, rdata_q, rdata_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [15:0] dq_s1_q, dq_s2_q, dq_s3_q;

   assign cyc.ack = ack_q;
   assign cyc.rdata = rdata_q;

   // Next state of the cycle engine
   always_comb begin
      st_d = st_q;
      wr_d = wr_q;
      ack_d = 1'b0;
      ce_n_d = o_ce_n;
      oe_n_d = o_oe_n;
      we_n_d = o_we_n;
      dq_oe_d = o_dq_oe;
      addr_d = o_addr;
      dq_d = o_dq;
      rdata_d = rdata_q;
      cnt_d = cnt_q;
      case (st_q)
         E_IDLE: begin
            if (cyc.req) begin
               wr_d = cyc.wr;
               addr_d = cyc.addr;
               dq_d = cyc.wdata;
               dq_oe_d = cyc.wr;
               ce_n_d = 1'b0; // Fresh chip-enable fall per cycle, refreshes status
               st_d = E_SETUP;
            end
         end
         E_SETUP: begin
            we_n_d = ~wr_q;
            oe_n_d = wr_q;
            cnt_d = wr_q ? CNT_W'(WE_CYC - 1) : CNT_W'(ACC_CYC + SYNC_CYC - 1);
            st_d = E_STROBE;
         end
         E_STROBE: begin
            if (cnt_q == '0) begin
               we_n_d = 1'b1;
               oe_n_d = 1'b1;
               if (!wr_q && dq_s2_q == dq_s3_q) begin
                  rdata_d = dq_s3_q;
               end
               st_d = E_HOLD;
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         E_HOLD: begin
            ce_n_d = 1'b1;
            dq_oe_d = 1'b0;
            ack_d = 1'b1;
            st_d = E_IDLE;
         end
         default: st_d = E_IDLE;
      endcase
   end

   // Registers of the cycle engine and data pin synchroniser
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         st_q <= E_IDLE;
         wr_q <= 1'b0;
         ack_q <= 1'b0;
         o_ce_n <= 1'b1;
         o_oe_n <= 1'b1;
         o_we_n <= 1'b1;
         o_dq_oe <= 1'b0;
         o_addr <= 24'h000000;
         o_dq <= 16'h0000;
         rdata_q <= 16'h0000;
         cnt_q <= '0;
         dq_s1_q <= 16'h0000;
         dq_s2_q <= 16'h0000;
         dq_s3_q <= 16'h0000;
      end else begin
         st_q <= st_d;
         wr_q <= wr_d;
         ack_q <= ack_d;
         o_ce_n <= ce_n_d;
         o_oe_n <= oe_n_d;
         o_we_n <= we_n_d;
         o_dq_oe <= dq_oe_d;
         o_addr <= addr_d;
         o_dq <= dq_d;
         rdata_q <= rdata_d;
         cnt_q <= cnt_d;
         dq_s1_q <= i_dq;
         dq_s2_q <= dq_s1_q;
         dq_s3_q <= dq_s2_q;
      end
   end
endmodule
`default_nettype wire

// File: core/nfc_ctrl.sv
`default_nettype none
// Notes on behaviour
// - Word program is command then data at target; then status mode.
// - Repeat buffered setup until status bit 7 shows buffer free.
// - Host writes count, start with data, then pairs inside range.
// - Confirm to original block address; anything else is sequence error.
// - Low program voltage sets bits 4 and 3; host clears error bits.
// - Second cycle holds count; up to 512 words; D0h starts programming. The code writes count minus one.
module nfc_ctrl (
   // Clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_NRST,
   // Software register port
   input wire logic [7:0] I_ADDR,
   input wire logic [31:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [31:0] O_RDATA,
   // Flash bus pins
   output logic O_CE_N,
   output logic O_OE_N,
   output logic O_WE_N,
   output logic [23:0] O_FL_ADDR,
   output logic [15:0] O_DQ,
   output logic O_DQ_OE,
   input wire logic [15:0] I_DQ,
   // Flash reset, power-down and ready/busy pins
   output logic O_RESET_POWERDOWN_N,
   input wire logic I_READY_BUSY
);
   import nfc_pkg::*;

   typedef enum {T_IDLE, T_CMD, T_DATA, T_READ, T_POLL, T_BUF_SETUP, T_BUF_CHK, T_BUF_CNT,
      T_BUF_WAIT, T_BUF_WR, T_BUF_CONF, T_RESET} nfc_state_t;

   nfc_cyc_if cyc ();

   nfc_state_t st_q, st_d, after_q, after_d;
   logic launched_q, launched_d, req_q, req_d, wr_q, wr_d;
   logic [23:0] caddr_q, caddr_d;
   logic [15:0] cwdata_q, cwdata_d, cmd_q, cmd_d;
   logic [3:0] op_q, op_d;
   logic [22:0] addr_q, addr_d;
   logic [15:0] data_q, data_d, bufdat_q, bufdat_d;
   logic [9:0] count_q, count_d, idx_q, idx_d;
   nfc_rmode_t rmode_q, rmode_d;
   logic [7:0] sr_q, sr_d;
   logic arg_err_q, arg_err_d, rst_pin_q, rst_pin_d;
   logic [CNT_W-1:0] rst_cnt_q, rst_cnt_d;
   logic rb_s1_q, rb_s2_q, rb_s3_q, rb_q, rb_d;
   logic [31:0] rdata_d;
   logic wr_ctrl, wr_bufdata, buf_bad;
   logic [10:0] page_end;
   logic [16:0] blk_end;

   assign cyc.req = req_q;
   assign cyc.wr = wr_q;
   assign cyc.addr = caddr_q;
   assign cyc.wdata = cwdata_q;

   nfc_bus_eng u_eng (
      .i_clk (I_SYS_CLK),
      .i_nrst (I_NRST),
      .cyc (cyc.eng),
      .o_ce_n (O_CE_N),
      .o_oe_n (O_OE_N),
      .o_we_n (O_WE_N),
      .o_addr (O_FL_ADDR),
      .o_dq (O_DQ),
      .o_dq_oe (O_DQ_OE),
      .i_dq (I_DQ)
   );

   // Register decode and buffered-program range checks
   assign wr_ctrl = I_WR && (I_ADDR == REG_CTRL);
   assign wr_bufdata = I_WR && (I_ADDR == REG_BUFDATA);
   assign page_end = {2'b00, addr_q[8:0]} + {1'b0, count_q};
   assign blk_end = {1'b0, addr_q[15:0]} + {7'h00, count_q};
   assign buf_bad = (count_q == '0) || (count_q > 10'(BUF_WORDS))
      || ((addr_q[8:0] != 9'h000) && (page_end > 11'(BUF_WORDS))
         && (count_q > 10'(BUF_SPLIT_WORDS)))
      || (blk_end > 17'(BLOCK_WORDS));

   // Next state of the sequencer and the software registers
   always_comb begin
      st_d = st_q;
      after_d = after_q;
      launched_d = launched_q;
      req_d = 1'b0;
      wr_d = wr_q;
      caddr_d = caddr_q;
      cwdata_d = cwdata_q;
      cmd_d = cmd_q;
      op_d = op_q;
      addr_d = addr_q;
      data_d = data_q;
      bufdat_d = bufdat_q;
      count_d = count_q;
      idx_d = idx_q;
      rmode_d = rmode_q;
      sr_d = sr_q;
      arg_err_d = arg_err_q;
      rst_pin_d = rst_pin_q;
      rst_cnt_d = rst_cnt_q;
      // Parameter registers are writable only while idle
      if (I_WR && st_q == T_IDLE) begin
         if (I_ADDR == REG_ADDR) addr_d = I_WDATA[22:0];
         if (I_ADDR == REG_DATA) data_d = I_WDATA[15:0];
         if (I_ADDR == REG_COUNT) count_d = I_WDATA[9:0]; // Words only, no byte load
      end
      case (st_q)
         T_IDLE: begin
            if (wr_ctrl) begin
               op_d = I_WDATA[3:0];
               arg_err_d = 1'b0;
               after_d = T_READ;
               st_d = T_CMD;
               case (I_WDATA[3:0])
                  OP_RD_ARRAY: cmd_d = CMD_READ_ARRAY;
                  OP_RD_STATUS: cmd_d = CMD_READ_STATUS;
                  OP_RD_ID: cmd_d = CMD_READ_ID;
                  OP_RD_QUERY: cmd_d = CMD_QUERY;
                  OP_CLR_STATUS: begin
                     cmd_d = CMD_CLR_STATUS;
                     sr_d = 8'h00;
                     after_d = T_IDLE;
                  end
                  OP_WORD_PROG: begin
                     cmd_d = CMD_WORD_PROG;
                     after_d = T_DATA;
                  end
                  OP_BUF_PROG: begin
                     if (buf_bad) begin
                        arg_err_d = 1'b1;
                        st_d = T_IDLE;
                     end else begin
                        idx_d = '0;
                        st_d = T_BUF_SETUP;
                     end
                  end
                  OP_RESET: begin
                     rst_pin_d = 1'b0;
                     rst_cnt_d = CNT_W'(RST_CYC - 1);
                     st_d = T_RESET;
                  end
                  default: begin
                     arg_err_d = 1'b1;
                     st_d = T_IDLE;
                  end
               endcase
            end
         end
         T_CMD: begin
            if (!launched_q) begin
               req_d = 1'b1;
               launched_d = 1'b1;
               wr_d = 1'b1;
               caddr_d = {addr_q, 1'b0}; // Address line zero unused
               cwdata_d = cmd_q;
            end else if (cyc.ack) begin
               launched_d = 1'b0;
               st_d = after_q;
               case (op_q)
                  OP_RD_ARRAY: rmode_d = RM_ARRAY;
                  OP_RD_STATUS: rmode_d = RM_STATUS;
                  OP_RD_ID: rmode_d = RM_ID;
                  OP_RD_QUERY: rmode_d = RM_QUERY;
                  OP_WORD_PROG: rmode_d = RM_STATUS;
                  default: rmode_d = rmode_q;
               endcase
            end
         end
         T_DATA: begin
            if (!launched_q) begin
               req_d = 1'b1;
               launched_d = 1'b1;
               wr_d = 1'b1;
               caddr_d = {addr_q, 1'b0};
               cwdata_d = data_q;
            end else if (cyc.ack) begin
               launched_d = 1'b0;
               st_d = T_POLL;
            end
         end
         T_READ: begin
            if (!launched_q) begin
               req_d = 1'b1;
               launched_d = 1'b1;
               wr_d = 1'b0;
               caddr_d = {addr_q, 1'b0}; // Identifier offsets on line one upward
            end else if (cyc.ack) begin
               launched_d = 1'b0;
               st_d = T_IDLE;
               if (rmode_q == RM_STATUS) begin
                  data_d = {8'h00, cyc.rdata[7:0]};
                  if (cyc.rdata[SB_READY]) sr_d = cyc.rdata[7:0];
               end else begin
                  data_d = cyc.rdata;
               end
            end
         end
         T_POLL: begin
            // Each poll is a fresh read cycle; low bits float until ready
            if (!launched_q) begin
               req_d = 1'b1;
               launched_d = 1'b1;
               wr_d = 1'b0;
               caddr_d = {addr_q, 1'b0};
            end else if (cyc.ack) begin
               launched_d = 1'b0;
               if (cyc.rdata[SB_READY]) begin
                  sr_d = cyc.rdata[7:0];
                  st_d = T_IDLE;
               end
            end
         end
         T_BUF_SETUP: begin
            if (!launched_q) begin
               req_d = 1'b1;
               launched_d = 1'b1;
               wr_d = 1'b1;
               caddr_d = {addr_q, 1'b0};
               cwdata_d = CMD_BUF_PROG;
            end else if (cyc.ack) begin
               launched_d = 1'b0;
               rmode_d = RM_STATUS;
               st_d = T_BUF_CHK;
            end
         end
         T_BUF_CHK: begin
            if (!launched_q) begin
               req_d = 1'b1;
               launched_d = 1'b1;
               wr_d = 1'b0;
               caddr_d = {addr_q, 1'b0};
            end else if (cyc.ack) begin
               launched_d = 1'b0;
               st_d = cyc.rdata[SB_READY] ? T_BUF_CNT : T_BUF_SETUP;
            end
         end
         T_BUF_CNT: begin
            if (!launched_q) begin
               req_d = 1'b1;
               launched_d = 1'b1;
               wr_d = 1'b1;
               caddr_d = {addr_q, 1'b0};
               cwdata_d = 16'(count_q - 10'd1);
            end else if (cyc.ack) begin
               launched_d = 1'b0;
               st_d = T_BUF_WAIT;
            end
         end
         T_BUF_WAIT: begin
            if (wr_bufdata) begin
               bufdat_d = I_WDATA[15:0];
               st_d = T_BUF_WR;
            end
         end
         T_BUF_WR: begin
            if (!launched_q) begin
               req_d = 1'b1;
               launched_d = 1'b1;
               wr_d = 1'b1;
               caddr_d = {addr_q + {13'h0000, idx_q}, 1'b0};
               cwdata_d = bufdat_q;
            end else if (cyc.ack) begin
               launched_d = 1'b0;
               idx_d = idx_q + 10'd1;
               st_d = (idx_q == count_q - 10'd1) ? T_BUF_CONF : T_BUF_WAIT;
            end
         end
         T_BUF_CONF: begin
            if (!launched_q) begin
               req_d = 1'b1;
               launched_d = 1'b1;
               wr_d = 1'b1;
               caddr_d = {addr_q, 1'b0};
               cwdata_d = CMD_CONFIRM;
            end else if (cyc.ack) begin
               launched_d = 1'b0;
               st_d = T_POLL;
            end
         end
         T_RESET: begin
            if (rst_cnt_q == '0) begin
               rst_pin_d = 1'b1;
               rmode_d = RM_ARRAY;
               launched_d = 1'b0;
               st_d = T_IDLE;
            end else begin
               rst_cnt_d = rst_cnt_q - CNT_W'(1);
            end
         end
         default: st_d = T_IDLE;
      endcase
      // A reset order aborts any operation in flight
      if (wr_ctrl && I_WDATA[3:0] == OP_RESET && st_q != T_IDLE && st_q != T_RESET) begin
         op_d = OP_RESET;
         rst_pin_d = 1'b0;
         rst_cnt_d = CNT_W'(RST_CYC - 1);
         req_d = 1'b0;
         st_d = T_RESET;
      end
   end

   // Ready/busy pin qualified once the last two stages agree
   assign rb_d = (rb_s2_q == rb_s3_q) ? rb_s3_q : rb_q;

   // Read data for the software port, present only the cycle after a read
   always_comb begin
      rdata_d = 32'h00000000;
      if (I_RD) begin
         case (I_ADDR)
            REG_CTRL: rdata_d = {28'h0000000, op_q};
            REG_ADDR: rdata_d = {9'h000, addr_q};
            REG_DATA: rdata_d = {16'h0000, data_q};
            REG_COUNT: rdata_d = {22'h000000, count_q};
            REG_STATUS: begin
               rdata_d[ST_BUSY] = (st_q != T_IDLE);
               rdata_d[ST_NEED_DATA] = (st_q == T_BUF_WAIT);
               rdata_d[ST_ARG_ERR] = arg_err_q;
               rdata_d[ST_READY_PIN] = rb_q;
               rdata_d[ST_MODE +: 2] = rmode_q;
               rdata_d[ST_STATUS_BYTE +: 8] = sr_q;
            end
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   // Sequencer and software register flip-flops
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_NRST) begin
         st_q <= T_IDLE;
         after_q <= T_IDLE;
         launched_q <= 1'b0;
         req_q <= 1'b0;
         wr_q <= 1'b0;
         caddr_q <= 24'h000000;
         cwdata_q <= 16'h0000;
         cmd_q <= 16'h0000;
         op_q <= 4'h0;
         addr_q <= 23'h000000;
         data_q <= 16'h0000;
         bufdat_q <= 16'h0000;
         count_q <= 10'h000;
         idx_q <= 10'h000;
         rmode_q <= RM_ARRAY;
         sr_q <= 8'h00;
         arg_err_q <= 1'b0;
         rst_pin_q <= 1'b1;
         rst_cnt_q <= '0;
         rb_s1_q <= 1'b0;
         rb_s2_q <= 1'b0;
         rb_s3_q <= 1'b0;
         rb_q <= 1'b0;
         O_RDATA <= 32'h00000000;
      end else begin
         st_q <= st_d;
         after_q <= after_d;
         launched_q <= launched_d;
         req_q <= req_d;
         wr_q <= wr_d;
         caddr_q <= caddr_d;
         cwdata_q <= cwdata_d;
         cmd_q <= cmd_d;
         op_q <= op_d;
         addr_q <= addr_d;
         data_q <= data_d;
         bufdat_q <= bufdat_d;
         count_q <= count_d;
         idx_q <= idx_d;
         rmode_q <= rmode_d;
         sr_q <= sr_d;
         arg_err_q <= arg_err_d;
         rst_pin_q <= rst_pin_d;
         rst_cnt_q <= rst_cnt_d;
         rb_s1_q <= I_READY_BUSY;
         rb_s2_q <= rb_s1_q;
         rb_s3_q <= rb_s2_q;
         rb_q <= rb_d;
         O_RDATA <= rdata_d;
      end
   end

   assign O_RESET_POWERDOWN_N = rst_pin_q;
endmodule
`default_nettype wire

// File: sim/nfc_flash_model.sv
`default_nettype none
// Behavioural flash device seen through its bus pins
module nfc_flash_model (
   // Bus strobes and reset pin
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic rp_n,
   // Address, data and ready/busy
   input wire logic [23:0] a,
   input wire logic [15:0] d,
   output logic [15:0] q,
   output logic rdy
);
   timeunit 1ns;
   timeprecision 1ns;
   import nfc_pkg::*;
   parameter logic [15:0] MAKER = 16'h00a5; // Arbitrary maker code
   nfc_rmode_t md;
   logic [7:0] st;
   logic [15:0] r, wd, nl;
   logic [2:0] ph;
   logic [9:0] n;
   logic bf;
   wire logic lk = a[23:17] == 7'h01;
   wire logic [7:0] o = a[8:1];
   initial begin
      md = RM_ARRAY;
      st = 8'h80;
      ph = 0;
      bf = 0;
      rdy = 1;
   end
   // Read data per mode; fresh on every strobe, inverted while released
   always_comb begin
      case (md)
         RM_STATUS: r = {8'h00, st[7] ? st : 8'h55};
         RM_ID: r = o == 8'h02 ? {15'h0, lk} : o == 8'h00 ? MAKER
            : (o == 8'h07 || (o >= 8'h80 && o <= 8'h88)) ? {8'h0c, o} : 16'h0;
         RM_QUERY: r = {8'h00, o};
         default: r = a[16:1];
      endcase
   end
   assign q = (!ce_n && !oe_n) ? r : ~r;
   // Command decode on the write strobe rising edge
   always @(posedge we_n or negedge rp_n) begin
      if (!rp_n) begin
         md <= RM_ARRAY;
         ph <= 0;
         st <= 8'h80;
      end else if (!ce_n) begin
         case (ph)
            1: begin
               wd <= d;
               st <= lk ? 8'h92 : 8'h00;
               rdy <= lk;
               ph <= 0;
            end
            2: begin
               nl <= d;
               n <= d[9:0]; // Word-wide count only
               ph <= 3;
            end
            3: if (n == 0) ph <= 4; else n <= n - 10'h1;
            4: begin
               st <= d == 16'h00d0 ? 8'h00 : 8'hb0;
               rdy <= d != 16'h00d0;
               ph <= 0;
            end
            default: case (d[7:0])
               8'hff: md <= RM_ARRAY;
               8'h70: md <= RM_STATUS;
               8'h90: md <= RM_ID;
               8'h98: md <= RM_QUERY;
               8'h50: st <= 8'h80;
               8'h40: begin
                  md <= RM_STATUS;
                  ph <= 1;
               end
               8'he8: begin
                  md <= RM_STATUS;
                  st <= {bf, 7'h00};
                  ph <= bf ? 3'd2 : 3'd0;
                  bf <= ~bf;
               end
               default: ;
            endcase
         endcase
      end
   end
   // Array work finishes after a fixed time
   always @(negedge rdy) begin
      #700;
      st[7] = 1'b1;
      rdy = 1'b1;
   end
endmodule
`default_nettype wire

// File: sim/nfc_ctrl_sva.sv
`default_nettype none
// Pin and port protocol checks of the flash controller
module nfc_ctrl_sva (
   input wire logic I_SYS_CLK,
   input wire logic I_NRST,
   input wire logic I_RD,
   input wire logic [31:0] O_RDATA,
   input wire logic O_CE_N,
   input wire logic O_OE_N,
   input wire logic O_WE_N,
   input wire logic [23:0] O_FL_ADDR,
   input wire logic O_DQ_OE,
   input wire logic O_RESET_POWERDOWN_N
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_NRST);
   // Write pulse: seven low cycles then high
   sequence s_we_pulse;
      !O_WE_N [*7] ##1 O_WE_N;
   endsequence
   sequence s_rst_hold;
      !O_RESET_POWERDOWN_N [*8];
   endsequence
   a_we_in_ce: assert property (!O_WE_N |-> !O_CE_N && O_DQ_OE)
      else $error("write strobe outside a driven chip enable");
   a_we_width: assert property ($fell(O_WE_N) |-> s_we_pulse)
      else $error("write strobe width wrong");
   a_oe_clean: assert property (!O_OE_N |-> O_WE_N && !O_DQ_OE && !O_CE_N)
      else $error("read strobe with bus driven");
   a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
      else $error("read data outside its cycle");
   a_addr_steady: assert property (!O_CE_N && !$past(O_CE_N) |-> $stable(O_FL_ADDR))
      else $error("address moved inside an access");
   a_addr_even: assert property (O_FL_ADDR[0] == 1'b0)
      else $error("byte address bit set");
   a_rst_hold: assert property ($fell(O_RESET_POWERDOWN_N) |-> s_rst_hold)
      else $error("reset pin pulse too short");
   a_ce_gap: assert property ($rose(O_CE_N) |-> O_CE_N [*2])
      else $error("chip enable gap too short");
endmodule
`default_nettype wire

// File: sim/nfc_ctrl_tb.sv
`default_nettype none
// Self-checking bench of the flash controller
module nfc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import nfc_pkg::*;
   logic clk = 0, nrst = 0, wr = 0, rd = 0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic ce_n, oe_n, we_n, dq_oe, rp_n, rdy;
   logic [23:0] fa;
   logic [15:0] dq, dqi, bus;
   int err_count = 0, n_tests = 0, cyc = 0;
   // Wire level of the shared data lines
   assign bus = dq_oe ? dq : dqi;
   always #5 clk = ~clk;
   nfc_ctrl u_dut (.I_SYS_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_CE_N(ce_n), .O_OE_N(oe_n),
      .O_WE_N(we_n), .O_FL_ADDR(fa), .O_DQ(dq), .O_DQ_OE(dq_oe), .I_DQ(bus),
      .O_RESET_POWERDOWN_N(rp_n), .I_READY_BUSY(rdy));
   nfc_flash_model u_fl (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n), .a(fa),
      .d(bus), .q(dqi), .rdy(rdy));
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic end_of_test;
      if (err_count == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 d = rdata;
   endtask
   // Run one operation and wait for busy to drop
   task automatic op(input logic [3:0] c, output logic [31:0] v);
      wr_reg(REG_CTRL, {28'h0, c});
      v = 32'h1;
      for (int i = 0; i < 4000 && v[ST_BUSY] !== 1'b0; i++) rd_reg(REG_STATUS, v);
   endtask
   task automatic t_modes;
      logic [31:0] v;
      op(OP_RD_STATUS, v);
      chk("mode", 32'h1, {30'h0, v[5:4]});
      rd_reg(REG_DATA, v);
      chk("sdata", 32'h80, {16'h0, v[15:0]});
      wr_reg(REG_ADDR, 32'h010002);
      op(OP_RD_ID, v);
      chk("idmode", 32'h2, {30'h0, v[5:4]});
      rd_reg(REG_DATA, v);
      chk("lock", 32'h1, {16'h0, v[15:0]});
      wr_reg(REG_ADDR, 32'h3);
      op(OP_RD_ID, v);
      rd_reg(REG_DATA, v);
      chk("compat", 32'h0, {16'h0, v[15:0]});
      wr_reg(REG_ADDR, 32'h7);
      op(OP_RD_ID, v);
      rd_reg(REG_DATA, v);
      chk("gpr", 32'h0c07, {16'h0, v[15:0]});
      wr_reg(REG_ADDR, 32'h80);
      op(OP_RD_ID, v);
      rd_reg(REG_DATA, v);
      chk("otplk", 32'h0c80, {16'h0, v[15:0]});
      op(OP_RD_QUERY, v);
      chk("qmode", 32'h3, {30'h0, v[5:4]});
   endtask
   task automatic t_prog;
      logic [31:0] v;
      wr_reg(REG_ADDR, 32'h20);
      wr_reg(REG_DATA, 32'h1234);
      op(OP_WORD_PROG, v);
      chk("pstat", 32'h80, {24'h0, v[15:8]});
      chk("pmode", 32'h1, {30'h0, v[5:4]});
      chk("rbpin", 32'h1, {31'h0, v[ST_READY_PIN]});
      chk("pdata", 32'h1234, {16'h0, u_fl.wd});
      wr_reg(REG_ADDR, 32'h010020);
      op(OP_WORD_PROG, v);
      chk("lkstat", 32'h92, {24'h0, v[15:8]});
      op(OP_CLR_STATUS, v);
      chk("clr", 32'h0, {24'h0, v[15:8]});
   endtask
   task automatic t_buf;
      logic [31:0] v;
      wr_reg(REG_COUNT, 32'd2);
      wr_reg(REG_ADDR, 32'h200);
      wr_reg(REG_CTRL, {28'h0, OP_BUF_PROG});
      repeat (2) begin
         v = 32'h0;
         for (int i = 0; i < 300 && v[ST_NEED_DATA] !== 1'b1; i++) rd_reg(REG_STATUS, v);
         wr_reg(REG_BUFDATA, 32'h5a5a);
      end
      op(OP_RD_STATUS, v);
      chk("bstat", 32'h80, {24'h0, v[15:8]});
      chk("bcount", 32'h1, {16'h0, u_fl.nl});
      wr_reg(REG_COUNT, 32'd300);
      wr_reg(REG_ADDR, 32'h1f0);
      op(OP_BUF_PROG, v);
      chk("split", 32'h1, {31'h0, v[ST_ARG_ERR]});
      wr_reg(REG_COUNT, 32'd2);
      wr_reg(REG_ADDR, 32'hffff);
      op(OP_BUF_PROG, v);
      chk("blkend", 32'h1, {31'h0, v[ST_ARG_ERR]});
   endtask
   task automatic t_reset;
      logic [31:0] v;
      wr_reg(REG_CTRL, {28'h0, OP_RESET});
      repeat (3) @(posedge clk);
      chk("rpin", 32'h0, {31'h0, rp_n});
      op(OP_RD_ARRAY, v);
      chk("amode", 32'h0, {30'h0, v[5:4]});
   endtask
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1;
      t_modes();
      t_prog();
      t_buf();
      t_reset();
      end_of_test();
   end
endmodule
bind nfc_ctrl nfc_ctrl_sva u_sva (.I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST), .I_RD(I_RD),
   .O_RDATA(O_RDATA), .O_CE_N(O_CE_N), .O_OE_N(O_OE_N), .O_WE_N(O_WE_N),
   .O_FL_ADDR(O_FL_ADDR), .O_DQ_OE(O_DQ_OE), .O_RESET_POWERDOWN_N(O_RESET_POWERDOWN_N));
`default_nettype wire
